// file: verilog/add_family_pkg.sv
// Constants and encodings for the integer add-family execution unit
package add_family_pkg;

    // Primary and extended opcodes
    localparam logic [5:0] OPC_PRIMARY_X      = 6'h1F;
    localparam logic [8:0] XO_SUM             = 9'h10A;
    localparam logic [8:0] XO_SUM_CARRY       = 9'h00A;
    localparam logic [8:0] XO_SUM_EXTENDED    = 9'h08A;
    localparam logic [8:0] XO_SUM_MINUS_ONE   = 9'h0EA;
    localparam logic [5:0] OPC_CONSTANT       = 6'h0E;
    localparam logic [5:0] OPC_CONSTANT_HIGH  = 6'h0F;
    localparam logic [5:0] OPC_CONSTANT_CARRY = 6'h0C;
    localparam logic [5:0] OPC_CONSTANT_CREC  = 6'h0D;

    // Instruction field positions, bit 0 is the word's least significant bit
    localparam int OPC_MSB    = 31;
    localparam int DEST_MSB   = 25;
    localparam int SRCA_MSB   = 20;
    localparam int SRCB_MSB   = 15;
    localparam int WRAP_EN_POS = 10;
    localparam int XO_MSB     = 9;
    localparam int REC_POS    = 0;

    localparam int DATA_WIDTH  = 32;
    localparam int GPR_COUNT   = 32;
    localparam int CONST_WIDTH = 16;

    // Condition field bit positions inside the 4-bit field
    localparam int CF_LT = 3;
    localparam int CF_GT = 2;
    localparam int CF_EQ = 1;
    localparam int CF_SO = 0;

    localparam logic [3:0] COND_FIELD_RESET = 4'h0;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_WRITE = 3'b100
    } phase_type;

endpackage : add_family_pkg

// file: verilog/gpr_file.sv
// General-purpose register file with registered read data
`timescale 1ns/1ps

module gpr_file
#(
    parameter int WIDTH = 32,
    parameter int COUNT = 32
)
(
    input  wire logic                     clk,
    input  wire logic [$clog2(COUNT)-1:0] rd_a_idx,
    input  wire logic [$clog2(COUNT)-1:0] rd_b_idx,
    output logic      [WIDTH-1:0]         rd_a_data,
    output logic      [WIDTH-1:0]         rd_b_data,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(COUNT)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data
);

    logic [WIDTH-1:0] mem [COUNT];

    // No reset: contents are undefined until software loads them
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_idx] <= wr_data;
        rd_a_data <= mem[rd_a_idx];
        rd_b_data <= mem[rd_b_idx];
    end

endmodule : gpr_file

// file: verilog/integer_add_family_datapath.sv
// Integer add-family execution unit with carry, overflow and condition updates
`timescale 1ns/1ps

// Functional notes
// [RULE_01] Register sum writes ra plus rb
// [RULE_02] Record bit updates condition field zero
// [RULE_03] Wrap enable updates sticky and signed flags
// [RULE_04] Carry forms set carry on unsigned overflow
// [RULE_05] Extended sum adds carry-in too
// [RULE_06] Constant op with source zero loads constant
// [RULE_07] Constant op adds, carry left unchanged
// [RULE_08] Constant carry op sets carry flag
// [RULE_09] Recording constant carry always updates condition
// [RULE_10] High constant shifted up, source zero loads
// [RULE_11] High constant adds to register only
// [RULE_12] Minus-one op adds ra, carry, minus one
// [RULE_13] Subtract-constant is negated constant carry op
// [RULE_14] Condition from signed compare plus sticky
// [RULE_15] Signed overflow flag, sticky only sets
module integer_add_family_datapath
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // Instruction issue from decode
    input  wire logic        ISSUE_VALID,
    input  wire logic [31:0] ISSUE_INSTR,
    output logic             ISSUE_READY,
    // Retirement
    output logic             DONE,
    output logic             ILLEGAL,
    output logic [31:0]      RESULT,
    // Exception and condition state
    output logic             UNSIGNED_WRAP_FLAG,
    output logic             SIGNED_WRAP_FLAG,
    output logic             STICKY_WRAP_FLAG,
    output logic [3:0]       COND_FIELD_ZERO
);

    localparam int IW = $clog2(add_family_pkg::GPR_COUNT);
    localparam int DW = add_family_pkg::DATA_WIDTH;
    localparam int CW = add_family_pkg::CONST_WIDTH;

    // Unit state outside the register file, registered in one place
    typedef struct packed
    {
        add_family_pkg::phase_type phase;
        logic                      ready;
        logic                      done;
        logic                      illegal;
        logic [31:0]               instr;
        logic [31:0]               result;
        logic                      unsigned_wrap_flag;
        logic                      signed_wrap_flag;
        logic                      sticky_wrap_flag;
        logic [3:0]                cond_field_zero;
    } state_type;

    state_type     cur;
    state_type     next_state;

    // Decode of the held instruction
    logic [5:0]    opcode;
    logic [8:0]    ext_opcode;
    logic [IW-1:0] dest_gpr;
    logic [IW-1:0] src_gpr_a;
    logic [IW-1:0] src_gpr_b;
    logic [CW-1:0] constant_field;
    logic          srca_is_zero;
    logic          cond_record_bit;
    logic          op_sum;
    logic          op_sum_carry;
    logic          op_sum_extended;
    logic          op_sum_minus_one;
    logic          op_constant;
    logic          op_constant_high;
    logic          op_constant_carry;
    logic          op_constant_crec;
    logic          op_extended_form;
    logic          legal;
    logic          writes_carry;
    logic          wrap_enable;
    logic          cond_record;

    // Adder path
    logic [DW-1:0] sign_extend;
    logic [DW-1:0] shifted_constant;
    logic [DW-1:0] operand_a;
    logic [DW-1:0] operand_b;
    logic          carry_in;
    logic [DW:0]   sum_full;
    logic          signed_wrap;
    logic          next_sticky;
    logic [3:0]    cond_value;

    // Register file access
    logic [IW-1:0] rd_a_idx;
    logic [IW-1:0] rd_b_idx;
    logic [DW-1:0] rd_a_data;
    logic [DW-1:0] rd_b_data;
    logic          gpr_wr_en;

    // Read data is registered, so indices come from the issue word at accept
    gpr_file
    #(
        .WIDTH (DW),
        .COUNT (add_family_pkg::GPR_COUNT)
    )
    gpr_file_i
    (
        .clk       (SYS_CLK),
        .rd_a_idx  (rd_a_idx),
        .rd_b_idx  (rd_b_idx),
        .rd_a_data (rd_a_data),
        .rd_b_data (rd_b_data),
        .wr_en     (gpr_wr_en),
        .wr_idx    (dest_gpr),
        .wr_data   (sum_full[DW-1:0])
    );

    always_comb
    begin
        opcode          = cur.instr[add_family_pkg::OPC_MSB -: 6];
        ext_opcode      = cur.instr[add_family_pkg::XO_MSB -: 9];
        dest_gpr        = cur.instr[add_family_pkg::DEST_MSB -: IW];
        src_gpr_a       = cur.instr[add_family_pkg::SRCA_MSB -: IW];
        src_gpr_b       = cur.instr[add_family_pkg::SRCB_MSB -: IW];
        constant_field  = cur.instr[CW-1:0];
        cond_record_bit = cur.instr[add_family_pkg::REC_POS];
        srca_is_zero    = (src_gpr_a == '0);

        op_sum           = (opcode == add_family_pkg::OPC_PRIMARY_X)
                           && (ext_opcode == add_family_pkg::XO_SUM); // RULE_01
        op_sum_carry     = (opcode == add_family_pkg::OPC_PRIMARY_X)
                           && (ext_opcode == add_family_pkg::XO_SUM_CARRY); // RULE_04
        op_sum_extended  = (opcode == add_family_pkg::OPC_PRIMARY_X)
                           && (ext_opcode == add_family_pkg::XO_SUM_EXTENDED); // RULE_05
        op_sum_minus_one = (opcode == add_family_pkg::OPC_PRIMARY_X)
                           && (ext_opcode == add_family_pkg::XO_SUM_MINUS_ONE); // RULE_12
        op_constant      = (opcode == add_family_pkg::OPC_CONSTANT); // RULE_06
        op_constant_high = (opcode == add_family_pkg::OPC_CONSTANT_HIGH); // RULE_10
        // Subtract-constant forms arrive here with a negated constant
        op_constant_carry = (opcode == add_family_pkg::OPC_CONSTANT_CARRY); // RULE_13
        // Records without a record bit; the other two such opcodes live elsewhere
        op_constant_crec  = (opcode == add_family_pkg::OPC_CONSTANT_CREC); // RULE_09
        op_extended_form  = op_sum | op_sum_carry | op_sum_extended | op_sum_minus_one;
        legal             = op_extended_form | op_constant | op_constant_high
                            | op_constant_carry | op_constant_crec;
        writes_carry      = op_sum_carry | op_sum_extended | op_sum_minus_one
                            | op_constant_carry | op_constant_crec; // RULE_04
        wrap_enable       = op_extended_form & cur.instr[add_family_pkg::WRAP_EN_POS]; // RULE_03
        cond_record       = (op_extended_form & cond_record_bit) | op_constant_crec; // RULE_02

        sign_extend      = {{(DW-CW){constant_field[CW-1]}}, constant_field};
        shifted_constant = {constant_field, {(DW-CW){1'b0}}}; // RULE_10

        // Source field zero means the value zero, not register zero
        if ((op_constant || op_constant_high) && srca_is_zero)
            operand_a = '0; // RULE_06
        else
            operand_a = rd_a_data;

        if (op_sum_minus_one)
            operand_b = '1; // RULE_12
        else if (op_constant_high)
            operand_b = shifted_constant; // RULE_11
        else if (op_constant || op_constant_carry || op_constant_crec)
            operand_b = sign_extend; // RULE_07
        else
            operand_b = rd_b_data;

        carry_in = (op_sum_extended || op_sum_minus_one) ? cur.unsigned_wrap_flag : 1'b0; // RULE_05
        sum_full = {1'b0, operand_a} + {1'b0, operand_b} + {{DW{1'b0}}, carry_in};

        signed_wrap = (operand_a[DW-1] == operand_b[DW-1])
                      && (sum_full[DW-1] != operand_a[DW-1]); // RULE_15
        next_sticky = cur.sticky_wrap_flag | (wrap_enable & signed_wrap); // RULE_15

        cond_value                         = 4'h0;
        cond_value[add_family_pkg::CF_LT]  = sum_full[DW-1]; // RULE_14
        cond_value[add_family_pkg::CF_EQ]  = (sum_full[DW-1:0] == '0);
        cond_value[add_family_pkg::CF_GT]  = !sum_full[DW-1] && (sum_full[DW-1:0] != '0);
        cond_value[add_family_pkg::CF_SO]  = next_sticky;

        if (cur.phase == add_family_pkg::ST_IDLE)
        begin
            rd_a_idx = ISSUE_INSTR[add_family_pkg::SRCA_MSB -: IW];
            rd_b_idx = ISSUE_INSTR[add_family_pkg::SRCB_MSB -: IW];
        end
        else
        begin
            rd_a_idx = src_gpr_a;
            rd_b_idx = src_gpr_b;
        end

        // Only the destination register is written, nothing else
        gpr_wr_en = (cur.phase == add_family_pkg::ST_EXEC) && legal; // RULE_11

        next_state = cur;
        case (cur.phase)
            add_family_pkg::ST_IDLE:
            begin
                next_state.done    = 1'b0;
                next_state.illegal = 1'b0;
                if (ISSUE_VALID && cur.ready)
                begin
                    next_state.instr = ISSUE_INSTR;
                    next_state.ready = 1'b0;
                    next_state.phase = add_family_pkg::ST_EXEC;
                end
            end
            add_family_pkg::ST_EXEC:
            begin
                next_state.done    = 1'b1;
                next_state.illegal = !legal;
                next_state.phase   = add_family_pkg::ST_WRITE;
                if (legal)
                    next_state.result = sum_full[DW-1:0]; // RULE_01
                if (writes_carry)
                    next_state.unsigned_wrap_flag = sum_full[DW]; // RULE_04
                if (wrap_enable)
                begin
                    next_state.signed_wrap_flag = signed_wrap; // RULE_03
                    next_state.sticky_wrap_flag = next_sticky;
                end
                if (cond_record)
                    next_state.cond_field_zero = cond_value; // RULE_02
            end
            add_family_pkg::ST_WRITE:
            begin
                next_state.done    = 1'b0;
                next_state.illegal = 1'b0;
                next_state.ready   = 1'b1;
                next_state.phase   = add_family_pkg::ST_IDLE;
            end
            default:
            begin
                next_state.done    = 1'b0;
                next_state.illegal = 1'b0;
                next_state.ready   = 1'b1;
                next_state.phase   = add_family_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cur.phase              <= add_family_pkg::ST_IDLE;
            cur.ready              <= 1'b1;
            cur.done               <= 1'b0;
            cur.illegal            <= 1'b0;
            cur.instr              <= 32'h0;
            cur.result             <= 32'h0;
            cur.unsigned_wrap_flag <= 1'b0;
            cur.signed_wrap_flag   <= 1'b0;
            cur.sticky_wrap_flag   <= 1'b0;
            cur.cond_field_zero    <= add_family_pkg::COND_FIELD_RESET;
        end
        else
            cur <= next_state;
    end

    assign ISSUE_READY        = cur.ready;
    assign DONE               = cur.done;
    assign ILLEGAL            = cur.illegal;
    assign RESULT             = cur.result;
    assign UNSIGNED_WRAP_FLAG = cur.unsigned_wrap_flag;
    assign SIGNED_WRAP_FLAG   = cur.signed_wrap_flag;
    assign STICKY_WRAP_FLAG   = cur.sticky_wrap_flag;
    assign COND_FIELD_ZERO    = cur.cond_field_zero;

    // Accepted word retires two edges later
    chk_accept_done: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_01
        (ISSUE_VALID && ISSUE_READY) |-> ##2 DONE)
        else $error("accepted instruction did not retire");

    chk_done_pulse: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_01
        DONE |=> !DONE)
        else $error("done stood longer than one cycle");

    chk_ready_drop: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_01
        (ISSUE_VALID && ISSUE_READY) |=> !ISSUE_READY)
        else $error("ready stayed high after accept");

    chk_carry_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_07
        (cur.phase == add_family_pkg::ST_EXEC && !writes_carry)
        |=> $stable(UNSIGNED_WRAP_FLAG))
        else $error("carry changed by a non-carry form");

    chk_wrap_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_03
        (cur.phase == add_family_pkg::ST_EXEC && !wrap_enable)
        |=> ($stable(SIGNED_WRAP_FLAG) && $stable(STICKY_WRAP_FLAG)))
        else $error("overflow flags changed without enable");

    chk_cond_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_02
        (cur.phase == add_family_pkg::ST_EXEC && !cond_record)
        |=> $stable(COND_FIELD_ZERO))
        else $error("condition field changed without record");

    chk_sticky_keep: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_15
        STICKY_WRAP_FLAG |=> STICKY_WRAP_FLAG)
        else $error("sticky flag was cleared");

    chk_cond_sticky: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // RULE_14
        (cur.phase == add_family_pkg::ST_EXEC && cond_record)
        |=> (COND_FIELD_ZERO[add_family_pkg::CF_SO] == STICKY_WRAP_FLAG))
        else $error("condition fourth bit differs from sticky flag");

    cov_carry_out: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        cur.phase == add_family_pkg::ST_EXEC && writes_carry && sum_full[DW]);

    cov_signed_wrap: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        cur.phase == add_family_pkg::ST_EXEC && wrap_enable && signed_wrap);

    cov_implicit_record: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        cur.phase == add_family_pkg::ST_EXEC && op_constant_crec);

    cov_illegal: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
        ILLEGAL);

endmodule : integer_add_family_datapath

// file: dv/add_issue_model.sv
// Decode-side model: holds one instruction until taken
`timescale 1ns/1ps
module add_issue_model
(
    // Handshake
    input  wire logic        clk,
    input  wire logic        ready,
    input  wire logic        req,
    input  wire logic [31:0] word,
    output logic             valid,
    output logic [31:0]      instr
);
    initial valid = 1'b0;
    initial instr = 32'h0;
    always @(posedge clk)
    begin
        if (valid && ready)
            {valid, instr} <= {1'b0, ~instr}; // Released word no longer shows
        else if (req)
            {valid, instr} <= {1'b1, word};
    end
endmodule : add_issue_model

// file: dv/integer_add_family_datapath_tb_top.sv
// Directed bench for the add-family unit
`timescale 1ns/1ps
module integer_add_family_datapath_tb_top;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        req  = 1'b0;
    logic [31:0] word = 32'h0;
    logic        vld, rdy, dn, ill, ca, ov, so;
    logic [31:0] ins, res;
    logic [3:0]  cr;
    int          err_total = 0;
    int          n_checks  = 0;
    always #2.5 clk = ~clk;
    add_issue_model add_issue_model_i (.clk(clk), .ready(rdy), .req(req), .word(word),
        .valid(vld), .instr(ins));
    integer_add_family_datapath integer_add_family_datapath_i (.SYS_CLK(clk),
        .SYS_RST(rst), .ISSUE_VALID(vld), .ISSUE_INSTR(ins), .ISSUE_READY(rdy),
        .DONE(dn), .ILLEGAL(ill), .RESULT(res), .UNSIGNED_WRAP_FLAG(ca),
        .SIGNED_WRAP_FLAG(ov), .STICKY_WRAP_FLAG(so), .COND_FIELD_ZERO(cr));
    task automatic cmp_word(input string name, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, e, s);
        end
    endtask : cmp_word
    task automatic cmp_flag(input string name, input logic e, input logic s);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %b seen %b", name, e, s);
        end
    endtask : cmp_flag
    task automatic cmp_cond(input string name, input logic [3:0] e, input logic [3:0] s);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, e, s);
        end
    endtask : cmp_cond
    task automatic run(input logic [31:0] w, input logic bad);
        int n;
        n = 0;
        @(posedge clk) {req, word} <= {1'b1, w};
        @(posedge clk) req <= 1'b0;
        while (dn !== 1'b1 && n < 50)
        begin
            @(posedge clk) #1;
            n++;
        end
        if (dn !== 1'b1)
        begin
            err_total++;
            $display("ERROR DONE expected 1 seen %b", dn);
            stop_test();
        end
        cmp_flag("ILLEGAL", bad, ill);
        $display("test %h done", w);
    endtask : run
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        run(32'h3820FFFF, 1'b0);
        cmp_word("RESULT", 32'hFFFFFFFF, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b0, ca);
        run(32'h3C408000, 1'b0);
        cmp_word("RESULT", 32'h80000000, res);
        run(32'h7C611214, 1'b0);
        cmp_word("RESULT", 32'h7FFFFFFF, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b0, ca);
        run(32'h30810001, 1'b0);
        cmp_word("RESULT", 32'h00000000, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b1, ca);
        run(32'h7CA11114, 1'b0);
        cmp_word("RESULT", 32'h80000000, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b1, ca);
        run(32'h38C30001, 1'b0);
        cmp_word("RESULT", 32'h80000000, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b1, ca);
        run(32'h3CE30001, 1'b0);
        cmp_word("RESULT", 32'h8000FFFF, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b1, ca);
        run(32'h7D0401D4, 1'b0);
        cmp_word("RESULT", 32'h00000000, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b1, ca);
        run(32'h3124FFFF, 1'b0);
        cmp_word("RESULT", 32'hFFFFFFFF, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b0, ca);
        run(32'h7D4401D4, 1'b0);
        cmp_word("RESULT", 32'hFFFFFFFF, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b0, ca);
        run(32'h7D631E15, 1'b0);
        cmp_word("RESULT", 32'hFFFFFFFE, res);
        cmp_flag("SIGNED_WRAP_FLAG", 1'b1, ov);
        cmp_flag("STICKY_WRAP_FLAG", 1'b1, so);
        cmp_cond("COND_FIELD_ZERO", 4'h9, cr);
        run(32'h7D842614, 1'b0);
        cmp_flag("SIGNED_WRAP_FLAG", 1'b0, ov);
        cmp_flag("STICKY_WRAP_FLAG", 1'b1, so);
        cmp_cond("COND_FIELD_ZERO", 4'h9, cr);
        run(32'h35A40000, 1'b0);
        cmp_word("RESULT", 32'h00000000, res);
        cmp_flag("UNSIGNED_WRAP_FLAG", 1'b0, ca);
        cmp_cond("COND_FIELD_ZERO", 4'h3, cr);
        run(32'h7DC31A14, 1'b0);
        cmp_word("RESULT", 32'hFFFFFFFE, res);
        cmp_flag("SIGNED_WRAP_FLAG", 1'b0, ov);
        cmp_cond("COND_FIELD_ZERO", 4'h3, cr);
        run(32'h00000000, 1'b1);
        stop_test();
    end
endmodule : integer_add_family_datapath_tb_top
